//--- hdl/pio_pkg.sv
package pio_pkg;

   // ***************************************************
   // port geometry
   // ***************************************************
   localparam int          NPORT = 11;
   localparam int          LPP   = 8;
   localparam int          NLINE = NPORT * LPP;
   localparam int          NGRP  = NLINE / 4;
   // which of the 88 slots are real lines (75 of them)
   localparam logic [87:0] LINE_PRESENT =
      88'h03_01FF_FFFF_FFFF_FFFF_FFFF;
   // flat index of port 8 line 5, which has no direction bit
   localparam int          P8L5_IDX = 8 * LPP + 5;
   localparam logic [87:0] DIR_IMPL =
      LINE_PRESENT & ~(88'h1 << P8L5_IDX);
   // lines taken as bus control pins in expansion modes
   localparam logic [87:0] BUS_LOCK = 88'h00_0000_FFFF_FFFF_FFFF;
   // lines whose pull-ups are cut in expansion modes
   localparam logic [87:0] PU_BLOCK = 88'h00_0000_FF0F_FFFF_FFFF;

   // ***************************************************
   // register map, word index = byte address / 4
   // ***************************************************
   localparam logic [5:0]  IDX_DIR0  = 6'h00;
   localparam logic [5:0]  IDX_DATA0 = 6'h10;
   localparam logic [5:0]  IDX_PUR0  = 6'h20;
   localparam logic [5:0]  IDX_PCR   = 6'h24;
   localparam logic [5:0]  IDX_MODE  = 6'h25;
   localparam int          NPUR      = 3;
   localparam int          PCR_LATCH_BIT = 0;
   localparam int          LATCH_PORT    = 1;

   typedef enum logic [1:0] {
      PIO_MODE_SINGLE = 2'b00,
      PIO_MODE_MEMEXP = 2'b01,
      PIO_MODE_MICRO  = 2'b11
   } pio_mode_e;

   typedef struct packed {
      logic [NLINE-1:0]  dir;
      logic [NLINE-1:0]  latch;
      logic [NPUR*8-1:0] pur;
      logic              latch_sel;
      logic [1:0]        mode;
      logic [NLINE-1:0]  pin_meta;
      logic [NLINE-1:0]  pin_sync;
      logic              ack;
      logic [7:0]        rdata;
   } pio_state_s;

   localparam pio_state_s STATE_RST = '0;

endpackage

//--- hdl/pio_ports.sv
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - 75 general lines over eleven ports, each but port 8 line 5 with its own direction bit.
// - A pin is a general line or bus pin as the mode sets.
// - Each direction bit maps to one line and picks input or output for it.
// - A direction bit of zero makes its line an input, a one an output.
// - In expansion modes direction bits of bus control pins ignore writes.
// - Port 8 line 5 has no direction bit and never drives.
// - Each data bit maps to one line with an output latch and a pin sense.
// - An input line reads its pin level, and a write still sets its latch.
// - An output line reads its latch; writes set it and it drives the pin.
// - With latch read select set, port 1 reads its latch in any direction.
// - Three pull-up registers hold one enable bit per group of four lines.
// - A pull-up is applied only to an enabled group line that is an input.
// - Expanded: pull-up bits of ports 0-3, 4 low half, 5 kept but unused.
module pio_ports
   import pio_pkg::*;
(
   input  wire logic              clk_i,
   input  wire logic              rst_n_i,
   input  wire logic [7:0]        avs_address_i,
   input  wire logic              avs_read_i,
   input  wire logic              avs_write_i,
   input  wire logic [31:0]       avs_writedata_i,
   input  wire logic [3:0]        avs_byteenable_i,
   output logic      [31:0]       avs_readdata_o,
   output logic                   avs_waitrequest_o,
   input  wire logic [NLINE-1:0]  pad_in_i,
   output logic      [NLINE-1:0]  pad_out_o,
   output logic      [NLINE-1:0]  pad_oe_o,
   output logic      [NLINE-1:0]  pullup_en_o
);

   // ***************************************************
   // helpers
   // ***************************************************
   function automatic logic [7:0] port_byte(input logic [NLINE-1:0] v,
                                            input int p);
      port_byte = v[p*LPP +: LPP];
   endfunction

   function automatic logic is_ext(input logic [1:0] m);
      is_ext = (m == PIO_MODE_MEMEXP) || (m == PIO_MODE_MICRO);
   endfunction

   // ***************************************************
   // reset release
   // ***************************************************
   logic [1:0] rst_q;
   logic       rst_sync_n;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_q <= 2'b00;
      end else begin
         rst_q <= {rst_q[0], 1'b1};
      end
   end
   assign rst_sync_n = rst_q[1];

   // ***************************************************
   // state and bus decode
   // ***************************************************
   pio_state_s       s_q;
   pio_state_s       s_d;
   logic             req;
   logic             wr_take;
   logic [5:0]       idx;
   logic [7:0]       wbyte;
   logic [NLINE-1:0] lock;
   logic [NLINE-1:0] pu_grp;
   logic [7:0]       rd_val;
   logic [7:0]       sel;
   int               p;

   assign req     = avs_read_i | avs_write_i;
   assign idx     = avs_address_i[7:2];
   assign wbyte   = avs_writedata_i[7:0];
   // one wait state; the answer edge is the second edge of a request
   assign avs_waitrequest_o = req & ~s_q.ack;
   assign wr_take = avs_write_i & s_q.ack & avs_byteenable_i[0];
   // bus pins belong to the external bus while expanded
   assign lock    = is_ext(s_q.mode) ? BUS_LOCK : '0;

   always_comb begin
      pu_grp = '0;
      for (int g = 0; g < NGRP; g++) begin
         pu_grp[g*4 +: 4] = {4{s_q.pur[g]}};
      end
   end

   // ***************************************************
   // read path
   // ***************************************************
   always_comb begin
      rd_val = 8'h00;
      sel    = 8'h00;
      p      = 0;
      if (idx < IDX_DIR0 + 6'(NPORT)) begin
         p      = int'(idx - IDX_DIR0);
         rd_val = port_byte(s_q.dir & DIR_IMPL, p);
      end else if (idx >= IDX_DATA0 && idx < IDX_DATA0 + 6'(NPORT)) begin
         p   = int'(idx - IDX_DATA0);
         sel = port_byte(s_q.dir, p);
         if (p == LATCH_PORT && s_q.latch_sel) begin
            sel = 8'hFF;
         end
         rd_val = ((port_byte(s_q.latch, p) & sel)
                  | (port_byte(s_q.pin_sync, p) & ~sel))
                  & port_byte(LINE_PRESENT, p);
      end else if (idx >= IDX_PUR0 && idx < IDX_PUR0 + 6'(NPUR)) begin
         p      = int'(idx - IDX_PUR0);
         rd_val = s_q.pur[p*8 +: 8];
      end else if (idx == IDX_PCR) begin
         rd_val = 8'(s_q.latch_sel) << PCR_LATCH_BIT;
      end else if (idx == IDX_MODE) begin
         rd_val = {6'h00, s_q.mode};
      end
   end

   // ***************************************************
   // next state
   // ***************************************************
   always_comb begin
      s_d          = s_q;
      s_d.pin_meta = pad_in_i;
      s_d.pin_sync = s_q.pin_meta;
      s_d.ack      = req & ~s_q.ack;
      if (avs_read_i && !s_q.ack) begin
         s_d.rdata = rd_val;
      end
      if (wr_take) begin
         if (idx < IDX_DIR0 + 6'(NPORT)) begin
            // latch untouched here, so an old value drives at once
            for (int b = 0; b < LPP; b++) begin
               if (!lock[int'(idx - IDX_DIR0)*LPP + b]) begin
                  s_d.dir[int'(idx - IDX_DIR0)*LPP + b] =
                     wbyte[b]
                     & DIR_IMPL[int'(idx - IDX_DIR0)*LPP + b];
               end
            end
         end else if (idx >= IDX_DATA0
                      && idx < IDX_DATA0 + 6'(NPORT)) begin
            // written regardless of direction
            s_d.latch[int'(idx - IDX_DATA0)*LPP +: LPP] = wbyte;
         end else if (idx >= IDX_PUR0 && idx < IDX_PUR0 + 6'(NPUR)) begin
            s_d.pur[int'(idx - IDX_PUR0)*8 +: 8] = wbyte;
         end else if (idx == IDX_PCR) begin
            s_d.latch_sel = wbyte[PCR_LATCH_BIT];
         end else if (idx == IDX_MODE) begin
            s_d.mode = wbyte[1:0];
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         s_q <= STATE_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // ***************************************************
   // outputs
   // ***************************************************
   assign avs_readdata_o = {24'h00_0000, s_q.rdata};
   assign pad_out_o      = s_q.latch & LINE_PRESENT;
   assign pad_oe_o       = s_q.dir & DIR_IMPL;
   // resistor only on enabled input lines, cut on PU_BLOCK lines when expanded
   assign pullup_en_o    = pu_grp & ~s_q.dir & LINE_PRESENT
                           & ~(is_ext(s_q.mode) ? PU_BLOCK : '0);

   // ***************************************************
   // assertions
   // ***************************************************
   a_dir_write_sets: assert property (
      @(posedge clk_i) disable iff (!rst_sync_n)
      wr_take && idx == IDX_DIR0 + 6'd6 && !is_ext(s_q.mode)
      |=> pad_oe_o[55:48] == $past(wbyte))
      else $error("direction write not applied");

   a_dir_lock_hold: assert property (
      @(posedge clk_i) disable iff (!rst_sync_n)
      wr_take && idx == IDX_DIR0 && is_ext(s_q.mode)
      |=> $stable(s_q.dir[7:0]))
      else $error("locked direction bits changed");

   a_no_p85_drive: assert property (
      @(posedge clk_i) disable iff (!rst_sync_n)
      !pad_oe_o[P8L5_IDX])
      else $error("port 8 line 5 driven");

   a_latch_drives: assert property (
      @(posedge clk_i) disable iff (!rst_sync_n)
      wr_take && idx == IDX_DATA0 + 6'd6
      |=> pad_out_o[55:48] == $past(wbyte))
      else $error("latch write not on pin");

   a_input_reads_pin: assert property (
      @(posedge clk_i) disable iff (!rst_sync_n)
      avs_read_i && s_q.ack && idx == IDX_DATA0 + 6'd6
      |-> (avs_readdata_o[7:0] & ~$past(s_q.dir[55:48]))
          == ($past(s_q.pin_sync[55:48]) & ~$past(s_q.dir[55:48])))
      else $error("input read not pin level");

   a_latch_select: assert property (
      @(posedge clk_i) disable iff (!rst_sync_n)
      avs_read_i && s_q.ack && idx == IDX_DATA0 + 6'd1
      && $past(s_q.latch_sel)
      |-> avs_readdata_o[7:0] == $past(s_q.latch[15:8]))
      else $error("latch read select ignored");

   a_pullup_input: assert property (
      @(posedge clk_i) disable iff (!rst_sync_n)
      (pullup_en_o & s_q.dir) == '0)
      else $error("pull-up on output line");

   a_pullup_block: assert property (
      @(posedge clk_i) disable iff (!rst_sync_n)
      is_ext(s_q.mode) |-> (pullup_en_o & PU_BLOCK) == '0)
      else $error("pull-up on bus pin");

   a_dir_keep_latch: assert property (
      @(posedge clk_i) disable iff (!rst_sync_n)
      wr_take && idx < IDX_DIR0 + 6'(NPORT) |=> $stable(pad_out_o))
      else $error("direction write changed latch");

   a_bus_answer: assert property (
      @(posedge clk_i) disable iff (!rst_sync_n)
      $rose(req) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
      else $error("bus answer not after one wait");

   a_output_reads_latch: assert property (
      @(posedge clk_i) disable iff (!rst_sync_n)
      avs_read_i && s_q.ack && idx == IDX_DATA0 + 6'd6
      |-> (avs_readdata_o[7:0] & $past(s_q.dir[55:48]))
          == ($past(s_q.latch[55:48]) & $past(s_q.dir[55:48])))
      else $error("output read not latch");

   a_latch_on_input: assert property (
      @(posedge clk_i) disable iff (!rst_sync_n)
      wr_take && idx == IDX_DATA0 + 6'd7 && s_q.dir[63:56] == 8'h00
      |=> pad_out_o[63:56] == $past(wbyte))
      else $error("latch write lost on input line");

   a_absent_quiet: assert property (
      @(posedge clk_i) disable iff (!rst_sync_n)
      ((pad_out_o | pad_oe_o | pullup_en_o) & ~LINE_PRESENT) == '0)
      else $error("absent line active");

   a_dir_read_back: assert property (
      @(posedge clk_i) disable iff (!rst_sync_n)
      avs_read_i && s_q.ack && idx == IDX_DIR0 + 6'd8
      |-> avs_readdata_o[7:0] == ($past(s_q.dir[71:64]) & DIR_IMPL[71:64]))
      else $error("direction read shows missing bit");

   a_pur_group: assert property (
      @(posedge clk_i) disable iff (!rst_sync_n)
      pullup_en_o[55:48]
      == ({{4{s_q.pur[13]}}, {4{s_q.pur[12]}}} & ~s_q.dir[55:48]))
      else $error("pull-up group mapping wrong");

   a_pullup_unblocked: assert property (
      @(posedge clk_i) disable iff (!rst_sync_n)
      !is_ext(s_q.mode) && s_q.pur[0] && s_q.dir[3:0] == 4'h0
      |-> pullup_en_o[3:0] == 4'hF)
      else $error("pull-up missing in single-chip mode");

   a_dir_port0_free: assert property (
      @(posedge clk_i) disable iff (!rst_sync_n)
      wr_take && idx == IDX_DIR0 && !is_ext(s_q.mode)
      |=> s_q.dir[7:0] == $past(wbyte))
      else $error("unlocked direction write lost");

   a_mode_write: assert property (
      @(posedge clk_i) disable iff (!rst_sync_n)
      wr_take && idx == IDX_MODE |=> s_q.mode == $past(wbyte[1:0]))
      else $error("mode write lost");

   a_pcr_write: assert property (
      @(posedge clk_i) disable iff (!rst_sync_n)
      wr_take && idx == IDX_PCR
      |=> s_q.latch_sel == $past(wbyte[PCR_LATCH_BIT]))
      else $error("latch read select write lost");

   a_byteen_ignore: assert property (
      @(posedge clk_i) disable iff (!rst_sync_n)
      avs_write_i && s_q.ack && !avs_byteenable_i[0]
      |=> $stable(s_q.dir) && $stable(s_q.latch) && $stable(s_q.pur))
      else $error("disabled byte written");

   // read data must stand until the next read is captured
   a_rdata_stands: assert property (
      @(posedge clk_i) disable iff (!rst_sync_n)
      !(avs_read_i && !s_q.ack) |=> $stable(avs_readdata_o))
      else $error("read data changed while idle");

   a_unmapped_zero: assert property (
      @(posedge clk_i) disable iff (!rst_sync_n)
      avs_read_i && s_q.ack && idx > IDX_MODE |-> avs_readdata_o == '0)
      else $error("unmapped read not zero");

endmodule // pio_ports

`default_nettype wire

//--- tb/pio_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
// ********
// far-side pins
// ********
module pio_pin_model (
   input  wire logic        clk_i,
   input  wire logic [87:0] out_i,
   input  wire logic [87:0] oe_i,
   input  wire logic [87:0] pu_i,
   input  wire logic [87:0] ext_en_i,
   input  wire logic [87:0] ext_val_i,
   output logic      [87:0] pad_o
);
   // floating lines wander, so a missing pull-up cannot pass by luck
   logic [87:0] flt_q = '0;
   always @(posedge clk_i) flt_q <= ~flt_q;
   assign pad_o = (oe_i & out_i) | (~oe_i & ext_en_i & ext_val_i)
      | (~oe_i & ~ext_en_i & (pu_i | flt_q));
endmodule // pio_pin_model
`default_nettype wire

//--- tb/tb_pio_ports.sv
`timescale 1ns/1ps
`default_nettype none
// ********
// testbench
// ********
module tb_pio_ports;
   import pio_pkg::*;
   logic             clk_i, rst_n_i, rd_i, wr_i, wait_o;
   logic [7:0]       addr_i;
   logic [31:0]      wdata_i, rdata_o;
   logic [3:0]       be_i, be_q;
   logic [NLINE-1:0] pin, pout, poe, pu, ext_en, ext_val;
   int               err_total, n_checks;

   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end

   pio_ports uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(addr_i),
      .avs_read_i(rd_i), .avs_write_i(wr_i), .avs_writedata_i(wdata_i),
      .avs_byteenable_i(be_i), .avs_readdata_o(rdata_o),
      .avs_waitrequest_o(wait_o), .pad_in_i(pin), .pad_out_o(pout),
      .pad_oe_o(poe), .pullup_en_o(pu));
   pio_pin_model pins (.clk_i(clk_i), .out_i(pout), .oe_i(poe), .pu_i(pu),
      .ext_en_i(ext_en), .ext_val_i(ext_val), .pad_o(pin));

   // ********
   // tasks
   // ********
   task automatic close_out();
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("FAIL t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
      chk({24'h00_0000, got}, {24'h00_0000, exp});
   endtask
   // request held until waitrequest is seen low at a rising edge
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      addr_i <= a;
      wr_i <= w;
      rd_i <= ~w;
      wdata_i <= {24'h00_0000, d};
      be_i <= be_q;
      do begin
         @(posedge clk_i);
         n++;
      end while (wait_o !== 1'b0 && n < 20);
      rd_i <= 1'b0;
      wr_i <= 1'b0;
      if (n >= 20) begin
         err_total++;
         close_out();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00);
      chk(rdata_o, {24'h00_0000, e});
   endtask
   // pins follow two edges of sync plus one of capture
   task automatic settle();
      repeat (3) @(posedge clk_i);
   endtask

   // ********
   // sequence
   // ********
   initial begin
      rst_n_i = 1'b0;
      rd_i = 1'b0;
      wr_i = 1'b0;
      addr_i = '0;
      wdata_i = '0;
      be_i = 4'hF;
      be_q = 4'hF;
      ext_en = '0;
      ext_val = '0;
      err_total = 0;
      n_checks = 0;
      repeat (3) @(posedge clk_i);
      rst_n_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rd(8'h00, 8'h00);
      rd(8'h80, 8'h00);
      rd(8'hFC, 8'h00);
      ext_en[55:48] <= 8'h0F;
      ext_val[55:48] <= 8'h03;
      wr(8'h18, 8'hF0);
      wr(8'h58, 8'hA5);
      settle();
      chk_pin(poe[55:48], 8'hF0);
      chk_pin(pout[55:48], 8'hA5);
      rd(8'h58, 8'hA3);
      ext_en[55:48] <= 8'h00;
      wr(8'h84, 8'h30);
      settle();
      chk_pin(pu[55:48], 8'h0F);
      rd(8'h58, 8'hAF);
      ext_en[63:56] <= 8'hFF;
      ext_val[63:56] <= 8'h0F;
      wr(8'h5C, 8'h5A);
      rd(8'h5C, 8'h0F);
      wr(8'h1C, 8'hFF);
      rd(8'h5C, 8'h5A);
      ext_en[15:8] <= 8'hFF;
      ext_val[15:8] <= 8'h00;
      wr(8'h44, 8'h66);
      wr(8'h90, 8'h01);
      rd(8'h44, 8'h66);
      wr(8'h90, 8'h00);
      rd(8'h44, 8'h00);
      wr(8'h20, 8'hFF);
      rd(8'h20, 8'hDF);
      be_q = 4'h0;
      wr(8'h20, 8'h00);
      be_q = 4'hF;
      rd(8'h20, 8'hDF);
      for (int m = 0; m < 2; m++) begin
         wr(8'h94, (m != 0) ? 8'h03 : 8'h01);
         wr(8'h00, 8'hFF);
         rd(8'h00, 8'h00);
         wr(8'h80, 8'h01);
         rd(8'h80, 8'h01);
         settle();
         chk_pin(pu[7:0], 8'h00);
         chk_pin(pu[55:48], 8'h0F);
      end
      wr(8'h94, 8'h00);
      settle();
      chk_pin(pu[7:0], 8'h0F);
      wr(8'h00, 8'hFF);
      rd(8'h00, 8'hFF);
      settle();
      chk_pin(poe[7:0], 8'hFF);
      chk_pin(pu[7:0], 8'h00);
      wr(8'h24, 8'hFF);
      wr(8'h64, 8'hFF);
      settle();
      chk_pin(poe[79:72], 8'h01);
      chk_pin(pout[79:72], 8'h01);
      rd(8'h64, 8'h01);
      // mid-run reset must clear direction, latch and pull-up registers again
      rst_n_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      rst_n_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      chk_pin(poe[7:0], 8'h00);
      chk_pin(pout[79:72], 8'h00);
      rd(8'h00, 8'h00);
      rd(8'h80, 8'h00);
      close_out();
   end
endmodule // tb_pio_ports
`default_nettype wire
